// *** rtl/flash_ctl.sv ***
// flash erase/protection control and programmer-mode command sequencer
`include "flash_consts.svh"

// Behaviour
// - erase runs exactly while the erase execute bit holds 1
// - dummy write of FF to even address; later reads return verify data
// - interrupts stay held off while the array is programmed or erased
// - reset or low-power entry aborts operation and clears control one and block select
// - with soft write allow clear, execute bits never start program or erase
// - cpu erase hits only selected blocks, zero selection protects every block; auto-erase ignores selection
// - fetch, exception or sleep during program/erase sets the fault flag
// - fault keeps registers, aborts at once, blocks re-entry, verify still allowed
// - only power-on reset clears the fault flag
// - socket side sees the array at 0000 through 7FFF
// - command 00 enters memory read; each following read returns array data
// - auto-program is command 40 plus 128 data writes, programmed together
// - auto-erase is 20 twice, status read is 71 twice, polled status
// - status read mode returns detailed result of the last operation
// - after an operation the device waits for a command before reading
// - memory read mode decodes command writes like the wait state
// - after power-up programmer mode starts in memory read
// - completion shows on status bits six and seven until next command other than status read
module flash_ctl #(
	parameter int AW = 15,
	parameter int NBLK = 8
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire flash_pkg::bus_req_t cpu_req,
	output logic [7:0] cpu_rdata,
	input wire logic low_power,
	input wire logic exc_start,
	input wire logic sleep_exec,
	input wire logic fetch_access,
	output logic irq_hold,
	input wire logic prog_mode_sel,
	input wire flash_pkg::sock_req_t sock,
	output logic [7:0] sock_dout
);
	import flash_pkg::*;

	logic [7:0] flash_control_one;
	logic flash_fault_flag;
	logic [NBLK-1:0] block_select_reg;
	logic [AW-1:0] verify_addr, sweep, ap_base, ram_addr;
	logic prog_act, erase_act, busy, err_evt, arr_hit;
	pmode_t pm;
	logic [7:0] cnt;
	logic st_done, st_ok, st_erase, st_addr_err;
	logic ram_we, cmd_state, cmd_wr, rd_arr;
	logic [7:0] ram_wdata, ram_rdata, page_rdata, reg_rdata;
	logic [1:0] sock_src;

	// ------------------------------------------------------------
	// protection and mode qualification
	// ------------------------------------------------------------
	assign arr_hit = cpu_req.addr[`ARR_WIN_BIT] && !cpu_req.addr[`ARR_TOP_BIT];
	// soft write allow, fault and low power all gate the execute bits
	assign prog_act = flash_control_one[`CTL_P] && flash_control_one[`CTL_WRITE_ALLOW]
		&& !flash_fault_flag && !low_power && !prog_mode_sel;
	assign erase_act = flash_control_one[`CTL_E] && flash_control_one[`CTL_WRITE_ALLOW]
		&& !flash_fault_flag && !low_power && !prog_mode_sel
		&& (|block_select_reg);
	assign busy = prog_act || erase_act;
	// runaway symptoms while the array is busy
	assign err_evt = fetch_access || exc_start || sleep_exec
		|| (cpu_req.rd && arr_hit);
	// interrupt controller must hold requests off while cells are stressed
	assign irq_hold = busy || pm == PM_AP_RUN || pm == PM_AE_RUN;

	// ------------------------------------------------------------
	// cpu registers
	// ------------------------------------------------------------
	// control one: cleared by reset and low-power entry, kept across a fault
	always_ff @(posedge mclk) begin
		if (!rst_b || low_power) begin
			flash_control_one <= `ZERO_BYTE;
		end else if (cpu_req.wr && cpu_req.addr == `OFS_CTL_ONE) begin
			flash_control_one <= cpu_req.wdata & `CTL_MASK;
		end
	end

	// block select: same initialisation as control one
	always_ff @(posedge mclk) begin
		if (!rst_b || low_power) begin
			block_select_reg <= '0;
		end else if (cpu_req.wr && cpu_req.addr == `OFS_BLK_SEL) begin
			block_select_reg <= cpu_req.wdata[NBLK-1:0];
		end
	end

	// fault flag is sticky; no register write reaches it, only power-on reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			flash_fault_flag <= 1'b0;
		end else if (busy && err_evt) begin
			flash_fault_flag <= 1'b1;
		end
	end

	// verify address latched by a dummy FF write to an even array address
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			verify_addr <= '0;
		end else if (cpu_req.wr && arr_hit && cpu_req.wdata == `ERASED_BYTE
			&& !cpu_req.addr[0] && (flash_control_one[`CTL_WIPE_CHK]
			|| flash_control_one[`CTL_WRITE_CHK])) begin
			verify_addr <= cpu_req.addr[AW-1:0];
		end
	end

	// register read data, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			reg_rdata <= `ZERO_BYTE;
			rd_arr <= 1'b0;
		end else begin
			rd_arr <= cpu_req.rd && arr_hit;
			unique case (cpu_req.addr)
				`OFS_CTL_ONE: reg_rdata <= flash_control_one;
				`OFS_CTL_TWO: reg_rdata <= {flash_fault_flag, 7'h00};
				`OFS_BLK_SEL: reg_rdata <= 8'(block_select_reg);
				default: reg_rdata <= `ZERO_BYTE;
			endcase
		end
	end
	assign cpu_rdata = rd_arr ? ram_rdata : reg_rdata;

	// ------------------------------------------------------------
	// erase sweep, shared by cpu erase and auto-erase
	// ------------------------------------------------------------
	// the sweep only advances while erase is live, so the pulse length is
	// exactly the time the execute bit stays set
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sweep <= '0;
		end else if (erase_act || pm == PM_AE_RUN) begin
			sweep <= sweep + 1'b1;
		end else begin
			sweep <= '0;
		end
	end

	// ------------------------------------------------------------
	// programmer command decoder
	// ------------------------------------------------------------
	assign cmd_state = pm == PM_MEM_READ || pm == PM_CMD_WAIT
		|| pm == PM_STATUS;
	assign cmd_wr = prog_mode_sel && sock.we && cmd_state;

	// command sequencer; powers up in memory read without a command
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pm <= PM_MEM_READ;
		end else if (!prog_mode_sel) begin
			pm <= PM_MEM_READ;
		end else begin
			unique case (pm)
				PM_MEM_READ, PM_CMD_WAIT, PM_STATUS: begin
					if (sock.we) begin
						unique case (sock.data)
							`CMD_READ: pm <= PM_MEM_READ;
							`CMD_APROG: pm <= PM_AP_LOAD;
							`CMD_AERASE: pm <= PM_AE_ARM;
							`CMD_STATUS: pm <= PM_SR_ARM;
							default: pm <= PM_CMD_WAIT;
						endcase
					end
				end
				PM_AP_LOAD: begin
					if (sock.we && cnt == `PAGE_LAST) begin
						pm <= PM_AP_RUN;
					end
				end
				PM_AP_RUN: begin
					if (cnt == `PAGE_BYTES) begin
						pm <= PM_CMD_WAIT;
					end
				end
				PM_AE_ARM: begin
					if (sock.we) begin
						pm <= (sock.data == `CMD_AERASE) ? PM_AE_RUN : PM_CMD_WAIT;
					end
				end
				PM_AE_RUN: begin
					if (&sweep) begin
						pm <= PM_CMD_WAIT;
					end
				end
				PM_SR_ARM: begin
					if (sock.we) begin
						pm <= (sock.data == `CMD_STATUS) ? PM_STATUS : PM_CMD_WAIT;
					end
				end
			endcase
		end
	end

	// byte counter for page load and page copy
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt <= `ZERO_BYTE;
		end else if (pm == PM_AP_LOAD) begin
			if (sock.we) begin
				cnt <= (cnt == `PAGE_LAST) ? `ZERO_BYTE : cnt + 1'b1;
			end
		end else if (pm == PM_AP_RUN) begin
			cnt <= cnt + 1'b1;
		end else begin
			cnt <= `ZERO_BYTE;
		end
	end

	// page base taken from the first data write only
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ap_base <= '0;
		end else if (pm == PM_AP_LOAD && sock.we && cnt == `ZERO_BYTE) begin
			ap_base <= sock.addr[AW-1:0];
		end
	end

	// result flags: kept until a command write other than status read
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_done <= 1'b0;
			st_ok <= 1'b0;
			st_erase <= 1'b0;
			st_addr_err <= 1'b0;
		end else if (cmd_wr && sock.data != `CMD_STATUS) begin
			st_done <= 1'b0;
			st_ok <= 1'b0;
			st_erase <= sock.data == `CMD_AERASE;
			st_addr_err <= 1'b0;
		end else if (pm == PM_AP_LOAD && sock.we && cnt == `ZERO_BYTE
			&& sock.addr[6:0] != 7'h00) begin
			st_addr_err <= 1'b1;
		end else if ((pm == PM_AP_RUN && cnt == `PAGE_BYTES)
			|| (pm == PM_AE_RUN && &sweep)) begin
			st_done <= 1'b1;
			st_ok <= !st_addr_err;
		end
	end

	// ------------------------------------------------------------
	// array port arbitration
	// ------------------------------------------------------------
	// the copy reads the latch one byte ahead, so the write trails by one
	always_comb begin
		ram_we = 1'b0;
		ram_wdata = `ERASED_BYTE;
		ram_addr = sock.addr[AW-1:0];
		if (prog_mode_sel && pm == PM_AP_RUN) begin
			ram_we = cnt != `ZERO_BYTE;
			ram_wdata = page_rdata;
			ram_addr = {ap_base[AW-1:7], 7'(cnt - 1'b1)};
		end else if (prog_mode_sel && pm == PM_AE_RUN) begin
			ram_we = 1'b1;
			ram_addr = sweep;
		end else if (erase_act) begin
			ram_we = block_select_reg[sweep[AW-1:`BLK_LSB]];
			ram_addr = sweep;
		end else if (!prog_mode_sel) begin
			ram_addr = (flash_control_one[`CTL_WIPE_CHK] || flash_control_one[`CTL_WRITE_CHK])
				? {verify_addr[AW-1:1], cpu_req.addr[0]}
				: cpu_req.addr[AW-1:0];
		end
	end

	array_ram #(.AW(AW)) i_array_ram (
		.mclk(mclk),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	page_latch #(.IW(7)) i_page_latch (
		.mclk(mclk),
		.we(pm == PM_AP_LOAD && sock.we),
		.widx(cnt[6:0]),
		.wdata(sock.data),
		.ridx(cnt[6:0]),
		.rdata(page_rdata)
	);

	// ------------------------------------------------------------
	// socket read data
	// ------------------------------------------------------------
	// source chosen at the read strobe: 0 array, 1 polling, 2 return code
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sock_src <= 2'h0;
		end else if (sock.re) begin
			sock_src <= (pm == PM_MEM_READ) ? 2'h0 : (pm == PM_STATUS) ? 2'h2 : 2'h1;
		end
	end
	always_comb begin
		unique case (sock_src)
			2'h0: sock_dout = ram_rdata;
			2'h2: sock_dout = {st_done, st_ok, st_erase, st_addr_err, 4'h0};
			default: sock_dout = {st_done, st_ok, 6'h00};
		endcase
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	property p_erase_gate;
		(ram_we && !prog_mode_sel) |-> (flash_control_one[`CTL_E]
			&& block_select_reg[ram_addr[AW-1:`BLK_LSB]] && !flash_fault_flag);
	endproperty
	a_erase_gate: assert property (p_erase_gate) else $error("erase outside selected block");
	property p_swe;
		(!flash_control_one[`CTL_WRITE_ALLOW] && !prog_mode_sel) |-> !ram_we;
	endproperty
	a_swe: assert property (p_swe) else $error("array written without write allow");
	property p_fault_set;
		(busy && err_evt) |=> flash_fault_flag && !busy;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not raised");
	property p_fault_hold;
		flash_fault_flag |=> flash_fault_flag;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault released");
	property p_no_reentry;
		(flash_fault_flag && !prog_mode_sel) |-> !ram_we;
	endproperty
	a_no_reentry: assert property (p_no_reentry) else $error("re-entry under fault");
	property p_lowpower;
		low_power |=> flash_control_one == `ZERO_BYTE && block_select_reg == '0;
	endproperty
	a_lowpower: assert property (p_lowpower) else $error("registers not cleared");
	property p_unknown;
		(cmd_wr && !(sock.data inside {`CMD_READ, `CMD_APROG, `CMD_AERASE, `CMD_STATUS}))
			|=> pm == PM_CMD_WAIT;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown command acted on");
	property p_ap_len;
		$rose(pm == PM_AP_RUN) |-> ##129 (pm == PM_CMD_WAIT && st_done);
	endproperty
	a_ap_len: assert property (p_ap_len) else $error("auto-program length wrong");
	property p_read_cmd;
		(cmd_wr && sock.data == `CMD_READ) |=> pm == PM_MEM_READ;
	endproperty
	a_read_cmd: assert property (p_read_cmd) else $error("read command ignored");
	property p_irq;
		ram_we |-> irq_hold;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupts not held");

	c_cpu_erase: cover property (erase_act ##1 !erase_act);
	c_fault: cover property ($rose(flash_fault_flag));
	c_auto_prog: cover property ($fell(pm == PM_AP_RUN));
	c_auto_erase: cover property ($fell(pm == PM_AE_RUN));
endmodule : flash_ctl

// *** rtl/flash_consts.svh ***
// offsets, field positions, command codes and reset values for the flash controller
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH
// register offsets (byte addresses, array window at bit 16)
`define OFS_CTL_ONE 17'h00000
`define OFS_CTL_TWO 17'h00004
`define OFS_BLK_SEL 17'h00008
`define ARR_WIN_BIT 16
`define ARR_TOP_BIT 15
// flash_control_one fields
`define CTL_P 0
`define CTL_E 1
`define CTL_WRITE_CHK 2
`define CTL_WIPE_CHK 3
`define CTL_WRITE_ALLOW 6
`define CTL_MASK 8'h4F
// flash_control_two fields
`define CTL_FAULT 7
// programmer command codes
`define CMD_READ 8'h00
`define CMD_APROG 8'h40
`define CMD_AERASE 8'h20
`define CMD_STATUS 8'h71
// status byte fields
`define ST_DONE 7
`define ST_OK 6
`define ST_ERASE 5
`define ST_ADDR_ERR 4
// values and counts
`define ERASED_BYTE 8'hFF
`define ZERO_BYTE 8'h00
`define PAGE_LAST 8'h7F
`define PAGE_BYTES 8'h80
`define BLK_LSB 12
`endif

// *** rtl/flash_pkg.sv ***
// types shared by the flash controller files
package flash_pkg;
	// programmer-mode command states, gray in declaration order
	typedef enum logic [2:0] {
		PM_MEM_READ = 3'b000,
		PM_CMD_WAIT = 3'b001,
		PM_AP_LOAD = 3'b011,
		PM_AP_RUN = 3'b010,
		PM_AE_ARM = 3'b110,
		PM_AE_RUN = 3'b111,
		PM_SR_ARM = 3'b101,
		PM_STATUS = 3'b100
	} pmode_t;
	// cpu register/array access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [16:0] addr;
		logic [7:0] wdata;
	} bus_req_t;
	// socket side access from the prom programmer
	typedef struct packed {
		logic we;
		logic re;
		logic [14:0] addr;
		logic [7:0] data;
	} sock_req_t;
endpackage : flash_pkg

// *** rtl/array_ram.sv ***
// single-port byte array standing in for the flash cells, registered read
module array_ram #(
	parameter int AW = 15
) (
	input wire logic mclk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:(1<<AW)-1];

	// no write-through: a write cycle reads back the old byte at its own address
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : array_ram

// *** rtl/page_latch.sv ***
// 128-byte page latch for auto-program, registered read
module page_latch #(
	parameter int IW = 7
) (
	input wire logic mclk,
	input wire logic we,
	input wire logic [IW-1:0] widx,
	input wire logic [7:0] wdata,
	input wire logic [IW-1:0] ridx,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:(1<<IW)-1];

	// separate ports so loading and copying never collide
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[widx] <= wdata;
		end
		rdata <= mem[ridx];
	end
endmodule : page_latch

// *** sim/prom_programmer.sv ***
// behavioural prom programmer that drives the socket side of the flash controller
`include "flash_consts.svh"

module prom_programmer (
	input wire logic mclk,
	output flash_pkg::sock_req_t sock,
	input wire logic [7:0] sock_dout
);
	timeunit 1ns;
	timeprecision 100ps;
	import flash_pkg::*;

	// idle socket at time zero
	initial begin
		sock = '0;
	end

	// ----------------------------------------
	// socket cycles
	// ----------------------------------------
	// one strobed cycle on mclk, which stands in for the 10 MHz programmer clock
	// afterwards the lines flip so a stale value never looks valid
	task automatic put(input logic [14:0] a, input logic [7:0] v);
		@(posedge mclk);
		sock.we <= 1'h1;
		sock.addr <= a;
		sock.data <= v;
		@(posedge mclk);
		sock.we <= 1'h0;
		sock.addr <= ~a;
		sock.data <= ~v;
	endtask : put

	// read strobe, data taken in the cycle after
	task automatic get(input logic [14:0] a, output logic [7:0] v);
		@(posedge mclk);
		sock.re <= 1'h1;
		sock.addr <= a;
		@(posedge mclk);
		sock.re <= 1'h0;
		sock.addr <= ~a;
		#1 v = sock_dout;
	endtask : get

	// command writes ignore the address, so any one will do
	task automatic cmd(input logic [7:0] c);
		put(15'h2A55, c);
	endtask : cmd

	// code, then 128 bytes in order; base low bits decide the address error
	task automatic page(input logic [14:0] base, input logic [7:0] seed);
		cmd(`CMD_APROG);
		for (int i = 0; i < 128; i++) begin
			put(base | 15'(i), seed + 8'(i));
		end
	endtask : page
endmodule : prom_programmer

// *** sim/flash_ctl_test.sv ***
// self-checking bench for the flash controller: cpu register side and socket side
`include "flash_consts.svh"

module flash_ctl_test;
	timeunit 1ns;
	timeprecision 100ps;
	import flash_pkg::*;

	logic mclk = 1'h0;
	logic rst_b = 1'h0;
	bus_req_t cpu = '0;
	logic [7:0] cpu_rdata;
	logic low_power = 1'h0;
	logic [2:0] src = 3'h0; // fetch, exception, sleep
	logic irq_hold;
	logic prog_mode_sel = 1'h0;
	sock_req_t sock;
	logic [7:0] sock_dout;
	logic [7:0] d;
	int error_cnt = 0;
	int cmp_count = 0;

	// 4 ns period
	always #2 mclk = ~mclk;

	flash_ctl #(.AW(15), .NBLK(8)) i_flash_ctl (
		.mclk(mclk), .rst_b(rst_b), .cpu_req(cpu), .cpu_rdata(cpu_rdata),
		.low_power(low_power), .exc_start(src[1]), .sleep_exec(src[2]),
		.fetch_access(src[0]), .irq_hold(irq_hold), .prog_mode_sel(prog_mode_sel),
		.sock(sock), .sock_dout(sock_dout)
	);

	prom_programmer i_prom_programmer (.mclk(mclk), .sock(sock), .sock_dout(sock_dout));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", w, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic do_reset();
		@(posedge mclk);
		rst_b <= 1'h0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'h1;
	endtask : do_reset

	task automatic wr(input logic [16:0] a, input logic [7:0] v);
		@(posedge mclk);
		cpu.wr <= 1'h1;
		cpu.addr <= a;
		cpu.wdata <= v;
		@(posedge mclk);
		cpu.wr <= 1'h0;
	endtask : wr

	task automatic rd(input string w, input logic [16:0] a, input logic [7:0] e);
		@(posedge mclk);
		cpu.rd <= 1'h1;
		cpu.addr <= a;
		@(posedge mclk);
		cpu.rd <= 1'h0;
		#1 check(w, cpu_rdata, e);
	endtask : rd

	// irq_hold is combinational, so one settled cycle after the write is enough
	task automatic irq(input logic e);
		@(posedge mclk);
		#1 check("irq_hold", {7'h00, irq_hold}, {7'h00, e});
	endtask : irq

	task automatic sck(input string w, input logic [14:0] a, input logic [7:0] e);
		i_prom_programmer.get(a, d);
		check(w, d, e);
	endtask : sck

	task automatic two(input logic [7:0] c);
		i_prom_programmer.cmd(c);
		i_prom_programmer.cmd(c);
	endtask : two

	// bounded status polling until the done bit shows
	task automatic poll(input int n, input logic [7:0] e);
		for (int i = 0; i < n; i++) begin
			i_prom_programmer.get(15'h0000, d);
			if (d[7] === 1'h1) break;
		end
		check("poll", d, e);
	endtask : poll

	// a hang counts as a mismatch and ends the run the usual way
	initial begin
		#240000;
		error_cnt++;
		complete_run();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		do_reset();
		rd("ctl_one", `OFS_CTL_ONE, 8'h00);
		rd("ctl_two", `OFS_CTL_TWO, 8'h00);
		rd("blk_sel", `OFS_BLK_SEL, 8'h00);
		rd("unmapped", 17'h0000C, 8'h00);
		// software protection, then empty selection, then a real erase of block zero
		wr(`OFS_BLK_SEL, 8'h01);
		wr(`OFS_CTL_ONE, 8'h02);
		irq(1'h0);
		wr(`OFS_BLK_SEL, 8'h00);
		wr(`OFS_CTL_ONE, 8'h42);
		irq(1'h0);
		wr(`OFS_BLK_SEL, 8'h01);
		irq(1'h1);
		repeat (4200) @(posedge mclk);
		wr(`OFS_CTL_ONE, 8'h40);
		irq(1'h0);
		// verify on both ends of block zero, odd byte then even byte read after even dummy writes
		wr(`OFS_CTL_ONE, 8'h48);
		wr(17'h10FFE, `ERASED_BYTE);
		rd("verify hi", 17'h10FFF, 8'hFF);
		wr(17'h10000, `ERASED_BYTE);
		rd("verify lo", 17'h10000, 8'hFF);
		// every runaway source during a live erase trips the fault
		for (int k = 0; k < 4; k++) begin
			do_reset();
			wr(`OFS_BLK_SEL, 8'h01);
			wr(`OFS_CTL_ONE, 8'h42);
			irq(1'h1);
			if (k < 3) begin
				@(posedge mclk);
				src[k] <= 1'h1;
				@(posedge mclk);
				src <= 3'h0;
			end else begin
				// block zero was wiped above, so any byte of it reads as erased
				rd("busy read", 17'h10010, `ERASED_BYTE);
			end
			irq(1'h0);
			rd("fault", `OFS_CTL_TWO, 8'h80);
			rd("kept", `OFS_CTL_ONE, 8'h42);
		end
		// re-entry refused, verify still allowed, fault outlives writes and low power
		wr(`OFS_CTL_ONE, 8'h40);
		wr(`OFS_CTL_ONE, 8'h42);
		irq(1'h0);
		wr(`OFS_CTL_ONE, 8'h48);
		rd("verify set", `OFS_CTL_ONE, 8'h48);
		wr(`OFS_CTL_TWO, 8'h00);
		@(posedge mclk);
		low_power <= 1'h1;
		repeat (3) @(posedge mclk);
		low_power <= 1'h0;
		rd("lp ctl", `OFS_CTL_ONE, 8'h00);
		rd("lp blk", `OFS_BLK_SEL, 8'h00);
		rd("lp fault", `OFS_CTL_TWO, 8'h80);
		do_reset();
		rd("por fault", `OFS_CTL_TWO, 8'h00);
		// low power aborts a live erase
		wr(`OFS_BLK_SEL, 8'h01);
		wr(`OFS_CTL_ONE, 8'h42);
		@(posedge mclk);
		low_power <= 1'h1;
		irq(1'h0);
		@(posedge mclk);
		low_power <= 1'h0;
		// programmer mode starts in memory read, checked with one read at 0FFF
		@(posedge mclk);
		prog_mode_sel <= 1'h1;
		sck("power-up read", 15'h0FFF, 8'hFF);
		i_prom_programmer.page(15'h0080, 8'h30);
		irq(1'h1);
		poll(200, 8'hC0);
		two(`CMD_STATUS);
		sck("ap status", 15'h0000, 8'hC0);
		i_prom_programmer.cmd(`CMD_READ);
		for (int i = 0; i < 128; i++) begin
			sck("page", 15'h0080 + 15'(i), 8'h30 + 8'(i));
		end
		// misaligned page start still writes but ends abnormally
		i_prom_programmer.page(15'h0101, 8'h50);
		poll(200, 8'h80);
		two(`CMD_STATUS);
		sck("bad status", 15'h0000, 8'h90);
		i_prom_programmer.cmd(`CMD_READ);
		sck("bad page", 15'h0101, 8'h51);
		i_prom_programmer.cmd(8'h55);
		sck("unknown", 15'h0101, 8'h00);
		i_prom_programmer.cmd(`CMD_READ);
		two(`CMD_STATUS);
		sck("from read", 15'h0101, 8'h00);
		// auto-erase sweeps the whole array
		two(`CMD_AERASE);
		irq(1'h1);
		poll(17000, 8'hC0);
		sck("held", 15'h0000, 8'hC0);
		two(`CMD_STATUS);
		sck("ae status", 15'h0000, 8'hE0);
		i_prom_programmer.cmd(`CMD_READ);
		sck("erased lo", 15'h0080, 8'hFF);
		sck("erased top", 15'h7FFF, 8'hFF);
		complete_run();
	end
endmodule : flash_ctl_test
